// *** rtl/psr_power_status_regs.sv ***
`timescale 1ns/100ps
module psr_power_status_regs (
	input wire logic REF_CLK, // Core clock, 10 MHz.
	input wire logic RST_N, // Synchronous reset, active low.
	input wire logic CLK_EN, // Clock enable; low freezes all state.
	input wire logic [7:0] REG_ADDR, // Register address.
	input wire logic [15:0] REG_WDATA, // Write data.
	input wire logic REG_WR, // Write strobe, one cycle.
	input wire logic REG_RD, // Read strobe, one cycle.
	output logic [15:0] REG_RDATA, // Read data, registered.
	input wire logic PLL_LOCK_PIN, // Raw PLL lock from analog core.
	input wire logic [15:0] CAL_WORD, // Calibration word, core domain.
	input wire logic VCO_CAL_READY, // Oscillator calibration ready.
	input wire logic CAL_DONE, // Calibration complete.
	input wire logic CONFIG_DONE, // Configuration complete.
	input wire logic NVM_BUSY, // Memory erase or program running.
	input wire logic NVM_CRC_ERR, // Memory check error.
	input wire logic NVM_RD_ERR_EV, // Memory read-phase error pulse.
	input wire logic NVM_WR_ERR_EV, // Memory write-phase error pulse.
	input wire logic FREQ_LOCK, // Frequency lock after calibration.
	input wire logic RECAL_START, // Recalibration start pulse.
	output logic OUTPUT1_REGULATOR_OFF, // Channel 1 regulator off.
	output logic OUTPUT2_REGULATOR_OFF, // Channel 2 regulator off.
	output logic OUTPUT3_REGULATOR_OFF, // Channel 3 regulator off.
	output logic OUTPUT4_REGULATOR_OFF, // Channel 4 regulator off.
	output logic OSC_BUFFER_REGULATOR_OFF, // Oscillator buffer regulator off.
	output logic OSC_REGULATOR_OFF, // Oscillator regulator off.
	output logic OSC_BUFFER_OFF, // Oscillator buffer off.
	output logic CHARGE_PUMP_REGULATOR_OFF, // Charge pump regulator off.
	output logic LOCK_DETECT_OFF, // Lock detector disabled.
	output logic FB_PRESCALER_OFF, // Feedback prescaler off.
	output logic PRESCALER_A_OFF, // Prescaler A off.
	output logic PFD_OFF, // Phase detector off.
	output logic PRESCALER_OFF, // Prescaler off.
	output logic INPUT_PATH_OFF // Input path regulator off.
);

	// ==================================================================
	// Storage.
	logic [15:0] chan_pwr_r;
	logic [15:0] pll_pwr_r;
	logic [15:0] pll_pwr_nxt;
	logic post_rst_r;
	logic lock_meta_r;
	logic lock_sync_r;
	logic lock_prev_r;
	// Flag vectors are indexed by the sticky slot numbers.
	logic [psr_pkg::NUM_FLAGS-1:0] flag_set;
	logic [psr_pkg::NUM_FLAGS-1:0] flag_clr;
	logic [psr_pkg::NUM_FLAGS-1:0] flags;
	logic [15:0] status_word;
	logic [15:0] rd_mux;

	// ==================================================================
	// Address match, shared by the hit decodes; the range check and read selection compare REG_ADDR directly.
	function automatic logic addr_is(input logic [7:0] addr,
		input logic [7:0] target);
		return addr == target;
	endfunction

	// ==================================================================
	// Address decode.
	// One hit wire per written or cleared location keeps the write and
	// status-clear paths in agreement on which register is being reached.
	wire hit_chan = addr_is(REG_ADDR, psr_pkg::ADDR_CHAN_PWR);
	wire hit_pll = addr_is(REG_ADDR, psr_pkg::ADDR_PLL_PWR);
	wire hit_status = addr_is(REG_ADDR, psr_pkg::ADDR_STATUS);
	// Anything above the last register is an access error, never a wrap.
	wire out_of_range = REG_ADDR > psr_pkg::ADDR_LAST;
	// Strobes qualified by the address they are aimed at.
	wire wr_chan = REG_WR & hit_chan;
	wire wr_pll = REG_WR & hit_pll;
	wire rd_status = REG_RD & hit_status;
	// A fall of the synchronised lock, seen in the same cycle as the fall itself.
	wire lock_lost = lock_prev_r & ~lock_sync_r;

	// Prescaler bit is raised by hardware in the first cycle after reset.
	// A write landing in that same cycle still ends with the bit set, so
	// software cannot leave the prescaler running by racing the release.
	always_comb begin
		pll_pwr_nxt = wr_pll ? REG_WDATA : pll_pwr_r;
		if (post_rst_r) begin
			pll_pwr_nxt[psr_pkg::PS_BIT] = 1'b1;
		end
	end

	// ==================================================================
	// Power-control words, written in full on their address.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			chan_pwr_r <= psr_pkg::RST_CHAN_PWR;
			pll_pwr_r <= psr_pkg::RST_PLL_PWR;
		end else if (CLK_EN) begin
			if (wr_chan) begin
				chan_pwr_r <= REG_WDATA;
			end
			pll_pwr_r <= pll_pwr_nxt;
		end
	end

	// Marks the first enabled cycle after reset release.
	// Holding it for one enabled cycle opens the prescaler gates only
	// after the forced bit 1 has been stored in the PLL word.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			post_rst_r <= 1'b1;
		end else if (CLK_EN) begin
			post_rst_r <= 1'b0;
		end
	end

	// ==================================================================
	// Lock pin synchroniser and edge history.
	// The lock pin follows no clock of ours, so the first stage feeds
	// only the second; the third stage keeps the history for edge detection.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			lock_meta_r <= 1'b0;
			lock_sync_r <= 1'b0;
			lock_prev_r <= 1'b0;
		end else if (CLK_EN) begin
			lock_meta_r <= PLL_LOCK_PIN;
			lock_sync_r <= lock_meta_r;
			lock_prev_r <= lock_sync_r;
		end
	end

	// ==================================================================
	// Sticky flag sources and clears.
	// Out-of-range errors have no clear strobe; only reset removes them.
	assign flag_set[psr_pkg::FL_NVM_RD] = NVM_RD_ERR_EV;
	assign flag_clr[psr_pkg::FL_NVM_RD] = rd_status;
	assign flag_set[psr_pkg::FL_NVM_WR] = NVM_WR_ERR_EV;
	assign flag_clr[psr_pkg::FL_NVM_WR] = rd_status;
	assign flag_set[psr_pkg::FL_UNLOCK] = lock_lost;
	assign flag_clr[psr_pkg::FL_UNLOCK] = RECAL_START;
	assign flag_set[psr_pkg::FL_RD_ERR] = REG_RD & out_of_range;
	assign flag_clr[psr_pkg::FL_RD_ERR] = 1'b0;
	assign flag_set[psr_pkg::FL_WR_ERR] = REG_WR & out_of_range;
	assign flag_clr[psr_pkg::FL_WR_ERR] = 1'b0;

	// One flag cell per sticky status bit.
	// A set in the clear cycle wins, so an event that lands on the read
	// strobe is reported by the next read instead of being lost.
	genvar gi;
	generate
		for (gi = 0; gi < psr_pkg::NUM_FLAGS; gi++) begin : g_flag
			psr_sticky_flag u_flag (
				.clk(REF_CLK),
				.rst_n(RST_N),
				.ce(CLK_EN),
				.set(flag_set[gi]),
				.clr(flag_clr[gi]),
				.flag(flags[gi])
			);
		end
	endgenerate

	// ==================================================================
	// Status word assembly; writes to it are ignored.
	// Bit 1 comes from its sticky cell alone, so a cleared unlock always
	// means a recalibration or a reset and never a stray write.
	always_comb begin
		status_word = psr_pkg::RST_ZERO;
		status_word[psr_pkg::ST_LOCK_A] = lock_sync_r;
		status_word[psr_pkg::ST_VCO_RDY] = VCO_CAL_READY;
		status_word[psr_pkg::ST_NVM_RD] = flags[psr_pkg::FL_NVM_RD];
		status_word[psr_pkg::ST_NVM_WR] = flags[psr_pkg::FL_NVM_WR];
		status_word[psr_pkg::ST_RD_ERR] = flags[psr_pkg::FL_RD_ERR];
		status_word[psr_pkg::ST_WR_ERR] = flags[psr_pkg::FL_WR_ERR];
		status_word[psr_pkg::ST_CRC_ERR] = NVM_CRC_ERR;
		status_word[psr_pkg::ST_NVM_BUSY] = NVM_BUSY;
		status_word[psr_pkg::ST_CAL_DONE] = CAL_DONE;
		status_word[psr_pkg::ST_CFG_DONE] = CONFIG_DONE;
		status_word[psr_pkg::ST_UNLOCK] = flags[psr_pkg::FL_UNLOCK];
		status_word[psr_pkg::ST_LOCK] = FREQ_LOCK;
	end

	// Read selection; unmapped addresses read zero.
	// Locations below the power words belong to other blocks.
	always_comb begin
		unique case (REG_ADDR)
			psr_pkg::ADDR_CHAN_PWR: rd_mux = chan_pwr_r;
			psr_pkg::ADDR_PLL_PWR: rd_mux = pll_pwr_r;
			psr_pkg::ADDR_CAL_WORD: rd_mux = CAL_WORD;
			psr_pkg::ADDR_STATUS: rd_mux = status_word;
			default: rd_mux = psr_pkg::RST_ZERO;
		endcase
	end

	// ==================================================================
	// Read data register, loaded on each read strobe.
	// The status word is latched as it stood at the strobe, so a clear on
	// read and the value returned always belong to the same cycle.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= psr_pkg::RST_ZERO;
		end else if (CLK_EN && REG_RD) begin
			REG_RDATA <= rd_mux;
		end
	end

	// ==================================================================
	// Block controls follow the stored bits directly, apart from the gated prescaler and phase detector controls.
	// Reserved bits are stored and read back but drive nothing.
	assign OUTPUT1_REGULATOR_OFF = chan_pwr_r[psr_pkg::CH1_BIT];
	assign OUTPUT2_REGULATOR_OFF = chan_pwr_r[psr_pkg::CH2_BIT];
	assign OUTPUT3_REGULATOR_OFF = chan_pwr_r[psr_pkg::CH3_BIT];
	assign OUTPUT4_REGULATOR_OFF = chan_pwr_r[psr_pkg::CH4_BIT];
	assign OSC_BUFFER_REGULATOR_OFF = pll_pwr_r[psr_pkg::OSCBUF_REG_BIT];
	assign OSC_REGULATOR_OFF = pll_pwr_r[psr_pkg::OSC_REG_BIT];
	assign OSC_BUFFER_OFF = pll_pwr_r[psr_pkg::OSCBUF_BIT];
	assign CHARGE_PUMP_REGULATOR_OFF = pll_pwr_r[psr_pkg::CP_REG_BIT];
	assign LOCK_DETECT_OFF = pll_pwr_r[psr_pkg::LOCKDET_BIT];
	assign FB_PRESCALER_OFF = pll_pwr_r[psr_pkg::FBPS_BIT];
	// Prescaler controls stay low while reset is held and one cycle after.
	assign PRESCALER_A_OFF = pll_pwr_r[psr_pkg::PSA_BIT] & ~post_rst_r;
	assign PRESCALER_OFF = pll_pwr_r[psr_pkg::PS_BIT] & ~post_rst_r;
	// Phase detector stays off until calibration has completed.
	assign PFD_OFF = pll_pwr_r[psr_pkg::PFD_BIT] | ~CAL_DONE;
	// Stored as written; software is trusted to leave this clear.
	assign INPUT_PATH_OFF = pll_pwr_r[psr_pkg::INPATH_BIT];

endmodule

// *** rtl/psr_pkg.sv ***
package psr_pkg;

	// ==================================================================
	// Register map.
	localparam logic [7:0] ADDR_CHAN_PWR = 8'h04;
	localparam logic [7:0] ADDR_PLL_PWR = 8'h05;
	localparam logic [7:0] ADDR_CAL_WORD = 8'h06;
	localparam logic [7:0] ADDR_STATUS = 8'h07;
	localparam logic [7:0] ADDR_LAST = 8'h07;

	// ==================================================================
	// Reset values.
	localparam logic [15:0] RST_CHAN_PWR = 16'h0054;
	localparam logic [15:0] RST_PLL_PWR = 16'h0030;
	localparam logic [15:0] RST_ZERO = 16'h0000;

	// ==================================================================
	// Channel power word fields.
	localparam int CH4_BIT = 7;
	localparam int CH3_BIT = 5;
	localparam int CH2_BIT = 3;
	localparam int CH1_BIT = 1;

	// ==================================================================
	// PLL power word fields.
	localparam int OSCBUF_REG_BIT = 10;
	localparam int OSC_REG_BIT = 9;
	localparam int OSCBUF_BIT = 8;
	localparam int CP_REG_BIT = 7;
	localparam int LOCKDET_BIT = 6;
	localparam int FBPS_BIT = 5;
	localparam int PSA_BIT = 4;
	localparam int PFD_BIT = 2;
	localparam int PS_BIT = 1;
	localparam int INPATH_BIT = 0;

	// ==================================================================
	// Status word fields.
	localparam int ST_LOCK_A = 11;
	localparam int ST_VCO_RDY = 10;
	localparam int ST_NVM_RD = 9;
	localparam int ST_NVM_WR = 8;
	localparam int ST_RD_ERR = 7;
	localparam int ST_WR_ERR = 6;
	localparam int ST_CRC_ERR = 5;
	localparam int ST_NVM_BUSY = 4;
	localparam int ST_CAL_DONE = 3;
	localparam int ST_CFG_DONE = 2;
	localparam int ST_UNLOCK = 1;
	localparam int ST_LOCK = 0;

	// ==================================================================
	// Sticky flag slots.
	localparam int NUM_FLAGS = 5;
	localparam int FL_NVM_RD = 0;
	localparam int FL_NVM_WR = 1;
	localparam int FL_UNLOCK = 2;
	localparam int FL_RD_ERR = 3;
	localparam int FL_WR_ERR = 4;

endpackage

// *** rtl/psr_sticky_flag.sv ***
`timescale 1ns/100ps
module psr_sticky_flag (
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic set, // Event that raises the flag.
	input wire logic clr, // Clear request.
	output logic flag // Stored flag.
);

	// ==================================================================
	// Flag storage; a set in the clear cycle keeps the flag high.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (ce) begin
			flag <= set | (flag & ~clr);
		end
	end

endmodule

// *** tb/psr_props.sv ***
`timescale 1ns/100ps
// ==================================================
// Checker for the power and status register bank.
module psr_props (
	input wire logic REF_CLK, // Clock.
	input wire logic RST_N, // Reset.
	input wire logic CLK_EN, // Enable.
	input wire logic [7:0] REG_ADDR, // Address.
	input wire logic [15:0] REG_WDATA, // Write data.
	input wire logic REG_WR, // Write strobe.
	input wire logic REG_RD, // Read strobe.
	input wire logic [15:0] REG_RDATA, // Read data.
	input wire logic PLL_LOCK_PIN, // Raw lock.
	input wire logic [15:0] CAL_WORD, // Calibration word.
	input wire logic CAL_DONE, // Calibration done.
	input wire logic OUTPUT1_REGULATOR_OFF, // Channel 1 off.
	input wire logic OUTPUT4_REGULATOR_OFF, // Channel 4 off.
	input wire logic CHARGE_PUMP_REGULATOR_OFF, // Charge pump off.
	input wire logic PFD_OFF, // Detector off.
	input wire logic PRESCALER_OFF // Prescaler off.
);
	// Accepted strobes only count while the clock enable is high.
	wire wr_ok = REG_WR && CLK_EN;
	wire rd_ok = REG_RD && CLK_EN;
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	// Power words drive their outputs the cycle after a write; detector gate and post-reset prescaler.
	a_chan_map: assert property (
		wr_ok && REG_ADDR == 8'h04 |=> OUTPUT4_REGULATOR_OFF ==
		$past(REG_WDATA[7]) && OUTPUT1_REGULATOR_OFF == $past(REG_WDATA[1]))
		else $error("channel outputs do not follow write");
	a_pump_map: assert property (
		wr_ok && REG_ADDR == 8'h05 |=>
		CHARGE_PUMP_REGULATOR_OFF == $past(REG_WDATA[7]))
		else $error("pump output does not follow write");
	a_pfd_gate: assert property (!CAL_DONE |-> PFD_OFF)
		else $error("detector on before calibration");
	a_ps_release: assert property (
		$rose(RST_N) && CLK_EN |=> PRESCALER_OFF)
		else $error("prescaler bit not set after reset");
	// Read path timing and contents.
	a_cal_read: assert property (
		rd_ok && REG_ADDR == 8'h06 |=> REG_RDATA == $past(CAL_WORD))
		else $error("calibration word read wrong");
	a_rdata_hold: assert property (!rd_ok |=> $stable(REG_RDATA))
		else $error("read data moved without read");
	a_rd_err_seen: assert property (
		(rd_ok && REG_ADDR > 8'h07) ##[1:4] (rd_ok && REG_ADDR == 8'h07)
		|=> REG_RDATA[7])
		else $error("read error flag missing");
	a_lock_seen: assert property (
		(PLL_LOCK_PIN && CLK_EN)[*4] ##0 (rd_ok && REG_ADDR == 8'h07)
		|=> REG_RDATA[11])
		else $error("lock flag missing");
endmodule
bind psr_power_status_regs psr_props psr_props_inst (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PLL_LOCK_PIN(PLL_LOCK_PIN),
	.CAL_WORD(CAL_WORD), .CAL_DONE(CAL_DONE),
	.OUTPUT1_REGULATOR_OFF(OUTPUT1_REGULATOR_OFF),
	.OUTPUT4_REGULATOR_OFF(OUTPUT4_REGULATOR_OFF),
	.CHARGE_PUMP_REGULATOR_OFF(CHARGE_PUMP_REGULATOR_OFF),
	.PFD_OFF(PFD_OFF), .PRESCALER_OFF(PRESCALER_OFF)
);

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
// ==================================================
// Self-checking bench for the power and status register bank.
module tb_top;
	logic REF_CLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, REG_WR = 1'b0;
	logic REG_RD = 1'b0, PLL_LOCK_PIN = 1'b0, VCO_CAL_READY = 1'b0;
	logic CAL_DONE = 1'b0, CONFIG_DONE = 1'b0, NVM_BUSY = 1'b0;
	logic NVM_CRC_ERR = 1'b0, NVM_RD_ERR_EV = 1'b0, NVM_WR_ERR_EV = 1'b0;
	logic FREQ_LOCK = 1'b0, RECAL_START = 1'b0;
	logic [7:0] REG_ADDR = 8'h00;
	logic [15:0] REG_WDATA = 16'h0000, CAL_WORD = 16'h0000, REG_RDATA;
	logic o1, o2, o3, o4, obr, osr, obf, cpr, ldo, fbp, psa, pfd, psc, inp;
	int mismatches = 0, check_count = 0, cyc = 0;
	always #50 REF_CLK = ~REF_CLK;
	psr_power_status_regs psr_power_status_regs_inst (
		.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PLL_LOCK_PIN(PLL_LOCK_PIN),
		.CAL_WORD(CAL_WORD), .VCO_CAL_READY(VCO_CAL_READY),
		.CAL_DONE(CAL_DONE), .CONFIG_DONE(CONFIG_DONE), .NVM_BUSY(NVM_BUSY),
		.NVM_CRC_ERR(NVM_CRC_ERR), .NVM_RD_ERR_EV(NVM_RD_ERR_EV),
		.NVM_WR_ERR_EV(NVM_WR_ERR_EV), .FREQ_LOCK(FREQ_LOCK),
		.RECAL_START(RECAL_START), .OUTPUT1_REGULATOR_OFF(o1),
		.OUTPUT2_REGULATOR_OFF(o2), .OUTPUT3_REGULATOR_OFF(o3),
		.OUTPUT4_REGULATOR_OFF(o4), .OSC_BUFFER_REGULATOR_OFF(obr),
		.OSC_REGULATOR_OFF(osr), .OSC_BUFFER_OFF(obf),
		.CHARGE_PUMP_REGULATOR_OFF(cpr), .LOCK_DETECT_OFF(ldo),
		.FB_PRESCALER_OFF(fbp), .PRESCALER_A_OFF(psa), .PFD_OFF(pfd),
		.PRESCALER_OFF(psc), .INPUT_PATH_OFF(inp)
	);
	// ==================================================
	// Compare, access and closing tasks.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge REF_CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge REF_CLK);
		REG_WR = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		@(negedge REF_CLK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge REF_CLK);
		REG_RD = 1'b0;
		chk(REG_RDATA, exp);
	endtask
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// A hung run counts as a mismatch and closes the report.
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 1000) begin
			mismatches++;
			end_sim();
		end
	end
	// ==================================================
	// Main sequence.
	initial begin
		repeat (3) @(negedge REF_CLK);
		chk({14'h0000, psa, psc}, 16'h0000);
		RST_N = 1'b1;
		rdc(8'h04, 16'h0054);
		rdc(8'h05, 16'h0032);
		rdc(8'h06, 16'h0000);
		rdc(8'h07, 16'h0000);
		chk({12'h000, psa, fbp, pfd, psc}, 16'h000f);
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, 16'h0054 | (16'h0002 << (2 * i)));
			chk({12'h000, o4, o3, o2, o1}, 16'h0001 << i);
		end
		// Bit 0 is never set and bit 1 is written back as read.
		for (int j = 6; j < 11; j++) begin
			wr(8'h05, 16'h0002 | (16'h0001 << j));
			chk({11'h000, obr, osr, obf, cpr, ldo},
				16'h1 << (j - 6));
		end
		chk({13'h0000, fbp, psa, inp}, 16'h0000);
		rdc(8'h05, 16'h0402);
		CAL_DONE = 1'b1;
		#1 chk({15'h0000, pfd}, 16'h0000);
		wr(8'h05, 16'h0006);
		chk({15'h0000, pfd}, 16'h0001);
		{VCO_CAL_READY, CONFIG_DONE, NVM_BUSY, NVM_CRC_ERR, FREQ_LOCK} = 5'h1f;
		PLL_LOCK_PIN = 1'b1;
		CAL_WORD = 16'h5a3c;
		wr(8'h06, 16'hffff);
		wr(8'h07, 16'hffff);
		rdc(8'h06, 16'h5a3c);
		rdc(8'h07, 16'h0c3d);
		NVM_BUSY = 1'b0;
		{NVM_RD_ERR_EV, NVM_WR_ERR_EV} = 2'b11;
		@(negedge REF_CLK);
		{NVM_RD_ERR_EV, NVM_WR_ERR_EV} = 2'b00;
		rdc(8'h07, 16'h0f2d);
		rdc(8'h07, 16'h0c2d);
		PLL_LOCK_PIN = 1'b0;
		repeat (6) @(negedge REF_CLK);
		rdc(8'h07, 16'h042f);
		PLL_LOCK_PIN = 1'b1;
		repeat (4) @(negedge REF_CLK);
		rdc(8'h07, 16'h0c2f);
		RECAL_START = 1'b1;
		@(negedge REF_CLK);
		RECAL_START = 1'b0;
		rdc(8'h07, 16'h0c2d);
		wr(8'h08, 16'h1234);
		rdc(8'h09, 16'h0000);
		rdc(8'h02, 16'h0000);
		rdc(8'h07, 16'h0ced);
		CLK_EN = 1'b0;
		wr(8'h04, 16'h0000);
		CLK_EN = 1'b1;
		rdc(8'h04, 16'h00d4);
		PLL_LOCK_PIN = 1'b0;
		repeat (4) @(negedge REF_CLK);
		rdc(8'h07, 16'h04ef);
		PLL_LOCK_PIN = 1'b1;
		RST_N = 1'b0;
		repeat (3) @(negedge REF_CLK);
		chk({14'h0000, psa, psc}, 16'h0000);
		RST_N = 1'b1;
		rdc(8'h04, 16'h0054);
		rdc(8'h05, 16'h0032);
		rdc(8'h07, 16'h0c2d);
		end_sim();
	end
endmodule
